/* design/tsc_scan_ctrl.v */
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`include "tsc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module tsc_scan_ctrl #(
	parameter CONV_CYC = `TSC_CONV_CYC,
	parameter DEB_CYC = `TSC_DEB_CYC
) (
	// Clock and reset.
	input wire sys_clk,
	input wire rst,
	// Avalon-MM register slave.
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	// Control pins from outside.
	input wire blank_n,
	input wire conv_hold_n,
	input wire data_hold_n,
	input wire scan_en,
	input wire scan_start,
	input wire scan_start_n,
	input wire chan_inc,
	input wire sw_sel,
	input wire [2:0] sw_chan,
	input wire [2:0] chan_bcd_in,
	input wire [2:0] dp_n,
	// Result of the converter, same clock domain.
	input wire [11:0] adc_bcd,
	input wire adc_ovr,
	input wire adc_pos,
	input wire adc_ovl,
	// Converter control.
	output reg conv_go,
	// Latched parallel outputs.
	output reg [11:0] data_bcd,
	output reg data_ovr,
	output reg data_pos,
	output reg data_ovl_n,
	output reg data_rdy,
	output reg data_rdy_n,
	output reg eoc_clk,
	// Channel and mode outputs.
	output reg [2:0] chan_bcd_out,
	output reg mode_sw,
	// Display drive.
	output reg [11:0] disp_bcd,
	output reg disp_ovr,
	output reg disp_pos,
	output reg disp_on,
	output reg [2:0] dp_on
);
	// =====================================================
	// Pin synchronisers
	// =====================================================
	localparam NPIN = 17;
	// Raw pin bundle.
	wire [NPIN-1:0] pin_raw;
	// Three flop stages per pin.
	reg [NPIN-1:0] s1_ff;
	reg [NPIN-1:0] s2_ff;
	reg [NPIN-1:0] s3_ff;
	// Accepted pin levels.
	reg [NPIN-1:0] pin_ff;
	assign pin_raw = {blank_n, conv_hold_n, data_hold_n, scan_en, scan_start, scan_start_n,
		chan_inc, sw_sel, sw_chan, chan_bcd_in, dp_n};
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi = gi + 1)
		begin : g_sync
			// A change counts once the second and third stages agree.
			always @(posedge sys_clk)
			begin
				s1_ff[gi] <= pin_raw[gi];
				s2_ff[gi] <= s1_ff[gi];
				s3_ff[gi] <= s2_ff[gi];
				// Under reset the accepted level follows the pin, so release brings no false edge.
				if (rst || (s2_ff[gi] == s3_ff[gi]))
					pin_ff[gi] <= s3_ff[gi];
			end
		end
	endgenerate
	// Named views of the accepted levels.
	wire blank_n_s = pin_ff[16];
	wire hold_n_s = pin_ff[15];
	wire dhold_n_s = pin_ff[14];
	wire scan_en_s = pin_ff[13];
	wire inc_s = pin_ff[10];
	wire sw_sel_s = pin_ff[9];
	wire [2:0] sw_chan_s = pin_ff[8:6];
	wire [2:0] ext_chan_s = pin_ff[5:3];
	wire [2:0] dp_n_s = pin_ff[2:0];
	// Both start inputs as active-high requests.
	wire [1:0] start_req = {pin_ff[12], ~pin_ff[11]};

	// =====================================================
	// Scan start debounce
	// =====================================================
	reg [22:0] deb_cnt_ff [0:1];
	reg [1:0] deb_ff;
	generate
		for (gi = 0; gi < 2; gi = gi + 1)
		begin : g_deb
			// The level is taken only after it stays put long enough.
			always @(posedge sys_clk)
			begin
				if (rst)
				begin
					deb_cnt_ff[gi] <= 23'h0;
					// Start from the current level of the pin, so reset fakes no start.
					deb_ff[gi] <= start_req[gi];
				end
				else if (start_req[gi] == deb_ff[gi])
					deb_cnt_ff[gi] <= 23'h0;
				else if (deb_cnt_ff[gi] == DEB_CYC[22:0] - 23'h1)
				begin
					deb_cnt_ff[gi] <= 23'h0;
					deb_ff[gi] <= start_req[gi];
				end
				else
					deb_cnt_ff[gi] <= deb_cnt_ff[gi] + 23'h1;
			end
		end
	endgenerate

	// =====================================================
	// Register bus
	// =====================================================
	// Software start and step pulses.
	reg sw_start_ff;
	reg sw_step_ff;
	// Register decode.
	wire bus_req = avs_read | avs_write;
	wire hit_ctrl = (avs_address == `TSC_CTRL_OFS);
	wire hit_stat = (avs_address == `TSC_STAT_OFS);
	wire hit_data = (avs_address == `TSC_DATA_OFS);
	reg busy_ff;
	reg [2:0] chan_ff;
	// One wait state; the write lands when wait request is seen low.
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			avs_waitrequest <= `TSC_WAIT_RST;
			avs_readdata <= 32'h0;
			sw_start_ff <= 1'b0;
			sw_step_ff <= 1'b0;
		end
		else
		begin
			sw_start_ff <= 1'b0;
			sw_step_ff <= 1'b0;
			if (bus_req && avs_waitrequest)
			begin
				avs_waitrequest <= 1'b0;
				if (avs_read && hit_ctrl)
					avs_readdata <= 32'h0;
				else if (avs_read && hit_stat)
					avs_readdata <= {24'h0, data_pos, data_ovl_n, mode_sw, data_rdy, busy_ff, chan_ff};
				else if (avs_read && hit_data)
					avs_readdata <= {19'h0, data_ovr, data_bcd};
				else
					avs_readdata <= 32'h0;
			end
			else
			begin
				avs_waitrequest <= 1'b1;
				// Writes of one pulse the start or step action.
				if (avs_write && hit_ctrl && avs_byteenable[0])
				begin
					sw_start_ff <= avs_writedata[`TSC_CTRL_START];
					sw_step_ff <= avs_writedata[`TSC_CTRL_STEP];
				end
			end
		end
	end

	// =====================================================
	// Internal clock and conversion pacing
	// =====================================================
	reg [22:0] tick_cnt_ff;
	reg tick_ff;
	reg flash_ff;
	// One tick every conversion period.
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			tick_cnt_ff <= 23'h0;
			tick_ff <= 1'b0;
			flash_ff <= 1'b0;
		end
		else if (tick_cnt_ff == CONV_CYC[22:0] - 23'h1)
		begin
			tick_cnt_ff <= 23'h0;
			tick_ff <= 1'b1;
			flash_ff <= ~flash_ff;
		end
		else
		begin
			tick_cnt_ff <= tick_cnt_ff + 23'h1;
			tick_ff <= 1'b0;
		end
	end
	// A tick converts only while the converter is not held.
	wire conv_tick = tick_ff & hold_n_s;

	// =====================================================
	// Result latches and display
	// =====================================================
	// Display follows each conversion and keeps the last one under hold.
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			conv_go <= 1'b0;
			disp_bcd <= 12'h0;
			disp_ovr <= 1'b0;
			disp_pos <= 1'b1;
			disp_on <= 1'b0;
			dp_on <= 3'h0;
			data_bcd <= 12'h0;
			data_ovr <= 1'b0;
			data_pos <= 1'b1;
			data_ovl_n <= 1'b1;
			eoc_clk <= 1'b0;
		end
		else
		begin
			conv_go <= conv_tick;
			eoc_clk <= 1'b0;
			if (conv_tick)
			begin
				disp_bcd <= adc_bcd;
				disp_ovr <= adc_ovr;
				disp_pos <= adc_pos;
				if (dhold_n_s)
				begin
					data_bcd <= adc_bcd;
					data_ovr <= adc_ovr;
					data_pos <= adc_pos;
					data_ovl_n <= ~adc_ovl;
					eoc_clk <= 1'b1;
				end
			end
			// Digits dark when blanked or, under overload, in the flash off phase.
			disp_on <= blank_n_s & ~(adc_ovl & flash_ff);
			// Points stay under their own inputs only.
			dp_on <= ~dp_n_s;
		end
	end

	// =====================================================
	// Scan sequencer
	// =====================================================
	reg inc_d_ff;
	reg [1:0] deb_d_ff;
	reg [2:0] step_ff;
	reg [4:0] settle_ff;
	// Start edge from either debounced input or software.
	wire start_lvl = |deb_ff;
	wire start_edge = (|(deb_ff & ~deb_d_ff)) | sw_start_ff;
	// Channel step from the pin edge or software.
	wire step_edge = (inc_s & ~inc_d_ff) | sw_step_ff;
	// Scanner drives the channel only when the switch is off.
	wire scan_mode = scan_en_s & ~sw_sel_s;
	wire [2:0] chan_nxt = (chan_ff == `TSC_LAST_CHAN) ? 3'h0 : chan_ff + 3'h1;
	// Sequence of scanning, stepping and settling.
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			// Edge detectors track their inputs through reset, so no step follows release.
			inc_d_ff <= inc_s;
			deb_d_ff <= deb_ff;
			busy_ff <= 1'b0;
			chan_ff <= 3'h0;
			step_ff <= 3'h0;
			settle_ff <= 5'h0;
			data_rdy <= 1'b0;
			data_rdy_n <= 1'b1;
		end
		else
		begin
			inc_d_ff <= inc_s;
			deb_d_ff <= deb_ff;
			if (start_edge)
			begin
				busy_ff <= 1'b1;
				step_ff <= 3'h0;
				settle_ff <= 5'h0;
				data_rdy <= 1'b0;
				data_rdy_n <= 1'b1;
			end
			else if (step_edge)
			begin
				settle_ff <= 5'h0;
				data_rdy <= 1'b0;
				data_rdy_n <= 1'b1;
				if (scan_mode)
				begin
					chan_ff <= chan_nxt;
					// Stop at channel zero once the start is gone.
					if (chan_nxt == 3'h0 && !start_lvl)
						busy_ff <= 1'b0;
				end
				else if (busy_ff)
				begin
					// Six readings of the addressed channel, then stop once the start is gone.
					if (step_ff == `TSC_LAST_STEP && !start_lvl)
						busy_ff <= 1'b0;
					step_ff <= (step_ff == `TSC_LAST_STEP) ? 3'h0 : step_ff + 3'h1;
				end
			end
			else if (tick_ff && busy_ff && !data_rdy)
			begin
				// Settling counts internal clock pulses.
				if (settle_ff == `TSC_SETTLE_TICKS - 5'h1)
				begin
					data_rdy <= 1'b1;
					data_rdy_n <= 1'b0;
				end
				settle_ff <= settle_ff + 5'h1;
			end
		end
	end

	// =====================================================
	// Channel selection outputs
	// =====================================================
	// Switch first, then scanner or external code.
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			chan_bcd_out <= 3'h0;
			mode_sw <= 1'b0;
		end
		else
		begin
			mode_sw <= sw_sel_s;
			if (sw_sel_s)
				chan_bcd_out <= sw_chan_s;
			else if (scan_en_s)
				chan_bcd_out <= chan_ff;
			else
				chan_bcd_out <= ext_chan_s;
		end
	end
endmodule
`default_nettype wire

/* include/tsc_defs.vh */
`ifndef TSC_DEFS_VH
`define TSC_DEFS_VH
// =====================================================
// Timing
// =====================================================
// System clock rate in hertz.
`define TSC_CLK_HZ 20000000
// Internal clock pulse period in milliseconds (5 per second).
`define TSC_CONV_MS 200
// Cycles per internal clock pulse.
`define TSC_CONV_CYC ((`TSC_CLK_HZ / 1000) * `TSC_CONV_MS)
// Debounce time of the scan start inputs in milliseconds.
`define TSC_DEB_MS 10
// Cycles a scan start input must stay stable.
`define TSC_DEB_CYC ((`TSC_CLK_HZ / 1000) * `TSC_DEB_MS)
// Internal clock pulses from a step to data ready.
`define TSC_SETTLE_TICKS 5'h10
// Highest channel number.
`define TSC_LAST_CHAN 3'h5
// Last reading index of a scan, so six readings per scan.
`define TSC_LAST_STEP 3'h5
// =====================================================
// Registers
// =====================================================
// Control register byte offset.
`define TSC_CTRL_OFS 4'h0
// Status register byte offset.
`define TSC_STAT_OFS 4'h4
// Latched reading register byte offset.
`define TSC_DATA_OFS 4'h8
// Control bit that starts a scan.
`define TSC_CTRL_START 0
// Control bit that steps the channel.
`define TSC_CTRL_STEP 1
// Reset value of the wait request flop.
`define TSC_WAIT_RST 1'b1
`endif

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; $display("BAD %s exp %0h got %0h", n, e, g); end end
// ==========
// Bench top.
// ==========
module tb_top;
	logic sys_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
	logic blank_n = 1'b1, conv_hold_n = 1'b1, scan_en = 1'b1, scan_start = 1'b0, scan_start_n = 1'b1, sw_sel = 1'b0;
	logic [2:0] sw_chan = 3'h0, chan_bcd_in = 3'h0, dp_n = 3'h7, dp_on, chan_bcd_out;
	logic [11:0] adc_bcd, data_bcd, disp_bcd, keep_bcd, prev_bcd = 12'h0;
	logic adc_ovr, adc_pos, adc_ovl, data_hold_n, conv_go, data_ovr, data_pos, data_ovl_n, data_rdy, data_rdy_n;
	logic eoc_clk, mode_sw, disp_ovr, disp_pos, disp_on, rdy_q = 1'b0, prev_pos = 1'b1, prev_ovl = 1'b0;
	logic prev_ovr = 1'b0;
	integer bad_count = 0, checked = 0, cycles = 0, exp_ch = 0, rdy_seen = 0, k;
	// The channel step is tied to the printer hold.
	tsc_scan_ctrl #(.CONV_CYC(100), .DEB_CYC(4)) uut (.sys_clk, .rst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .blank_n, .conv_hold_n, .data_hold_n,
		.scan_en, .scan_start, .scan_start_n, .chan_inc(data_hold_n), .sw_sel, .sw_chan, .chan_bcd_in, .dp_n,
		.adc_bcd, .adc_ovr, .adc_pos, .adc_ovl, .conv_go, .data_bcd, .data_ovr, .data_pos, .data_ovl_n, .data_rdy,
		.data_rdy_n, .eoc_clk, .chan_bcd_out, .mode_sw, .disp_bcd, .disp_ovr, .disp_pos, .disp_on, .dp_on);
	tsc_far_model far (.sys_clk, .conv_go, .data_rdy, .adc_bcd, .adc_ovr, .adc_pos, .adc_ovl, .data_hold_n);
	always #25 sys_clk = ~sys_clk;
	// Reference model: checks each latch update and the channel at each ready.
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 45000)
		begin
			bad_count++;
			tally_and_finish;
		end
		if (eoc_clk)
		begin
			`CHK("data_bcd", prev_bcd, data_bcd)
			`CHK("data_ovl_n", !prev_ovl, data_ovl_n)
			`CHK("data_pos", prev_pos, data_pos)
			`CHK("data_ovr", prev_ovr, data_ovr)
			`CHK("disp_bcd", prev_bcd, disp_bcd)
			`CHK("disp_ovr", prev_ovr, disp_ovr)
			`CHK("disp_pos", prev_pos, disp_pos)
		end
		if (data_rdy && !rdy_q)
		begin
			`CHK("chan_bcd_out", scan_en ? exp_ch[2:0] : chan_bcd_in, chan_bcd_out)
			`CHK("data_rdy_n", 1'b0, data_rdy_n)
			exp_ch = scan_en ? (exp_ch + 1) % 6 : exp_ch;
			rdy_seen++;
		end
		rdy_q <= data_rdy;
		prev_bcd <= adc_bcd;
		prev_pos <= adc_pos;
		prev_ovl <= adc_ovl;
		prev_ovr <= adc_ovr;
	end
	// One register access; waits for the answer.
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
	begin
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		@(posedge sys_clk);
		while (avs_waitrequest)
			@(posedge sys_clk);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	end
	endtask
	task tally_and_finish;
	begin
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask
	// Main sequence.
	initial
	begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		bus(1'b0, 4'h4, 32'h0);
		`CHK("status", 8'hc0, rd[7:0])
		bus(1'b1, 4'hc, 32'hffff);
		bus(1'b0, 4'hc, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		for (k = 1; k <= 6; k++)
		begin
			bus(1'b1, 4'h0, 32'h2);
			bus(1'b0, 4'h4, 32'h0);
			`CHK("step", 3'(k % 6), rd[2:0])
		end
		scan_start <= 1'b1;
		repeat (2) @(posedge sys_clk);
		scan_start <= 1'b0;
		repeat (20) @(posedge sys_clk);
		bus(1'b0, 4'h4, 32'h0);
		`CHK("glitch", 1'b0, rd[3])
		for (k = 0; k < 3; k++)
		begin
			scan_en <= (k < 2);
			chan_bcd_in <= 3'h3;
			scan_start <= (k != 1);
			scan_start_n <= (k != 1);
			repeat (30) @(posedge sys_clk);
			scan_start <= 1'b0;
			scan_start_n <= 1'b1;
			bus(1'b0, 4'h4, 32'h0);
			`CHK("busy", 1'b1, rd[3])
			do
				bus(1'b0, 4'h4, 32'h0);
			while (rd[3] === 1'b1);
			`CHK("readings", 6 * (k + 1), rdy_seen)
			`CHK("end chan", 3'h0, rd[2:0])
		end
		blank_n <= 1'b0;
		dp_n <= 3'b010;
		conv_hold_n <= 1'b0;
		repeat (10) @(posedge sys_clk);
		keep_bcd = disp_bcd;
		`CHK("disp_on", 1'b0, disp_on)
		`CHK("dp_on", 3'b101, dp_on)
		repeat (300) @(posedge sys_clk);
		`CHK("disp_bcd", keep_bcd, disp_bcd)
		conv_hold_n <= 1'b1;
		blank_n <= 1'b1;
		sw_sel <= 1'b1;
		sw_chan <= 3'h4;
		repeat (300) @(posedge sys_clk);
		`CHK("mode_sw", 1'b1, mode_sw)
		`CHK("sw chan", 3'h4, chan_bcd_out)
		sw_sel <= 1'b0;
		chan_bcd_in <= 3'h5;
		repeat (10) @(posedge sys_clk);
		`CHK("ext chan", 3'h5, chan_bcd_out)
		tally_and_finish;
	end
endmodule
`default_nettype wire

/* tb/tsc_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Pin timing checker.
// ==========
module tsc_chk #(
	parameter CONV_CYC = 100
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Control pins.
	input wire logic blank_n,
	input wire logic conv_hold_n,
	input wire logic data_hold_n,
	input wire logic scan_en,
	input wire logic sw_sel,
	input wire logic [2:0] sw_chan,
	input wire logic [2:0] chan_bcd_in,
	input wire logic [2:0] dp_n,
	// Converter side.
	input wire logic [11:0] adc_bcd,
	input wire logic adc_ovr,
	input wire logic adc_pos,
	input wire logic adc_ovl,
	input wire logic conv_go,
	// Outputs watched.
	input wire logic [11:0] data_bcd,
	input wire logic data_ovr,
	input wire logic data_pos,
	input wire logic data_ovl_n,
	input wire logic data_rdy,
	input wire logic data_rdy_n,
	input wire logic eoc_clk,
	input wire logic [2:0] chan_bcd_out,
	input wire logic mode_sw,
	input wire logic disp_on,
	input wire logic [2:0] dp_on
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// Cycles since the last converter start, and whether one was seen.
	integer gap_ff;
	logic seen_ff;
	// Spacing of converter starts, so the rate can be judged.
	always @(posedge sys_clk)
	begin
		gap_ff <= conv_go ? 0 : gap_ff + 1;
		seen_ff <= !rst && (seen_ff || conv_go);
	end
	property p_blank; (!blank_n)[*6] |-> !disp_on; endproperty
	a_blank: assert property (p_blank) else $error("digits lit while blanked");
	property p_hold; (!conv_hold_n)[*6] |-> !conv_go; endproperty
	a_hold: assert property (p_hold) else $error("conversion while held");
	property p_freeze; (!data_hold_n)[*6] |-> $stable(data_bcd) && !eoc_clk; endproperty
	a_freeze: assert property (p_freeze) else $error("data moved under hold");
	property p_ext; (!sw_sel && !scan_en && $stable(chan_bcd_in))[*8] |-> chan_bcd_out == chan_bcd_in; endproperty
	a_ext: assert property (p_ext) else $error("external channel ignored");
	property p_rate; conv_go && seen_ff |-> (gap_ff + 1) % CONV_CYC == 0; endproperty
	a_rate: assert property (p_rate) else $error("conversion spacing wrong");
	property p_bcd; eoc_clk |-> data_bcd == $past(adc_bcd) && data_ovr == $past(adc_ovr); endproperty
	a_bcd: assert property (p_bcd) else $error("latched digits wrong");
	property p_ovl; eoc_clk |-> data_ovl_n == !$past(adc_ovl); endproperty
	a_ovl: assert property (p_ovl) else $error("overload output wrong");
	property p_pos; eoc_clk |-> data_pos == $past(adc_pos); endproperty
	a_pos: assert property (p_pos) else $error("polarity output wrong");
	property p_mode; (sw_sel && $stable(sw_chan))[*8] |-> mode_sw && chan_bcd_out == sw_chan; endproperty
	a_mode: assert property (p_mode) else $error("switch selection ignored");
	property p_rdy; data_rdy_n == !data_rdy; endproperty
	a_rdy: assert property (p_rdy) else $error("ready pair disagrees");
	property p_eoc; eoc_clk |=> !eoc_clk; endproperty
	a_eoc: assert property (p_eoc) else $error("update pulse too long");
	property p_point; $stable(dp_n)[*8] |-> dp_on == ~dp_n; endproperty
	a_point: assert property (p_point) else $error("decimal point wrong");
	c_rdy: cover property ($rose(data_rdy));
	c_eoc: cover property (eoc_clk);
	c_sw: cover property (mode_sw);
endmodule
bind tsc_scan_ctrl tsc_chk #(.CONV_CYC(CONV_CYC)) u_chk (.sys_clk, .rst, .blank_n, .conv_hold_n, .data_hold_n,
	.scan_en, .sw_sel, .sw_chan, .chan_bcd_in, .dp_n, .adc_bcd, .adc_ovr, .adc_pos, .adc_ovl, .conv_go, .data_bcd,
	.data_ovr, .data_pos, .data_ovl_n, .data_rdy, .data_rdy_n, .eoc_clk, .chan_bcd_out, .mode_sw, .disp_on, .dp_on);
`default_nettype wire

/* tb/tsc_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Converter and printer model.
// ==========
module tsc_far_model (
	// Clock.
	input wire logic sys_clk,
	// Requests from the block.
	input wire logic conv_go,
	input wire logic data_rdy,
	// Converter result.
	output logic [11:0] adc_bcd = 12'h0,
	output logic adc_ovr = 1'b0,
	output logic adc_pos = 1'b1,
	output logic adc_ovl = 1'b0,
	// Printer hold, also wired to the channel step.
	output logic data_hold_n = 1'b1
);
	integer seed = 5638;
	integer busy_cnt = 0;
	integer i;
	logic rdy_q = 1'b0;
	// New random BCD result per conversion; printer holds data a while per ready.
	always @(posedge sys_clk)
	begin
		rdy_q <= data_rdy;
		if (conv_go)
		begin
			for (i = 0; i < 3; i++)
				adc_bcd[4*i+:4] <= 4'(($random(seed) & 32'h7fff) % 10);
			adc_ovr <= 1'($random(seed));
			adc_pos <= 1'($random(seed));
			adc_ovl <= 1'($random(seed));
		end
		busy_cnt <= (data_rdy && !rdy_q) ? 50 : (busy_cnt > 0 ? busy_cnt - 1 : 0);
		data_hold_n <= (busy_cnt <= 1) && !(data_rdy && !rdy_q);
	end
endmodule
`default_nettype wire
